// ---- hdl/pld_pkg.sv ----
// Purpose: shared constants for the pin cells, global cells and config
// Assumes: one 50 MHz clock; config words reached by word index
// Notes: every field position and index used by the design lives here
package pld_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int N_PIN = 20;
    localparam int N_LCC = 20;
    localparam int N_GRP = 2;
    localparam int SYNC_W = N_PIN + 2;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int SRC_W = 5;
    localparam int PC_CFG_W = 8;
    localparam int GC_CFG_W = 3;
    localparam int NUM_CFG = 23;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_PIN_FIRST = 5'h00;
    localparam logic [ADDR_W-1:0] IDX_GLOBAL_A = 5'h14;
    localparam logic [ADDR_W-1:0] IDX_LCC_POL = 5'h16;
    localparam logic [ADDR_W-1:0] IDX_CTRL = 5'h17;
    localparam logic [ADDR_W-1:0] IDX_SIG = 5'h18;
    localparam logic [ADDR_W-1:0] IDX_LCC_STAT = 5'h19;
    localparam logic [ADDR_W-1:0] IDX_ARR_STAT = 5'h1A;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PC_SRC_LSB = 0;
    localparam int PC_INV_BIT = 5;
    localparam int PC_LATCH_BIT = 6;
    localparam int PC_BYP_BIT = 7;
    localparam int GC_SEL_LSB = 0;
    localparam int GC_POL_BIT = 2;
    localparam int CTRL_SECURE_BIT = 0;
    localparam int CTRL_ERASE_BIT = 1;

    // ------------------------------------------------------------
    // global clock source codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_SRC_PIN_ONE = 2'h0,
        CLK_SRC_PIN_TWO = 2'h1,
        CLK_SRC_TERM = 2'h2
    } clk_src_e;

endpackage

// ---- hdl/global_cell.sv ----
// Purpose: one global cell: clock choice, pin cell polarity, group terms
// Assumes: clock pins already synchronised; terms from the same clock
// Notes: edges are one-cycle pulses of the sampled chosen clock
`timescale 1ns/1ps
module global_cell
    import pld_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [pld_pkg::GC_CFG_W-1:0] cfg, // select and polarity
    input wire logic clk_one, // stable first clock pin
    input wire logic clk_two, // stable second clock pin
    input wire logic clock_term, // array product term clock
    input wire logic reset_sum, // global reset sum term
    input wire logic preset_sum, // global preset sum term
    input wire logic type_term, // register type product term
    output logic rise, // chosen clock rose
    output logic fall, // chosen clock fell
    output logic io_edge, // active pin cell edge
    output logic io_level, // pin cell clock in active phase
    output logic g_reset, // group reset level
    output logic g_preset, // group preset level
    output logic g_type // group toggle mode level
);
    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
        logic io_edge;
        logic io_act;
        logic rst;
        logic pst;
        logic typ;
    } gc_state_s;

    gc_state_s cur_reg;
    gc_state_s cur_next;
    logic sel;

    // clock source mux and edge detection
    always_comb
    begin
        cur_next = cur_reg;
        case (clk_src_e'(cfg[GC_SEL_LSB +: 2]))
            CLK_SRC_PIN_ONE: sel = clk_one;
            CLK_SRC_PIN_TWO: sel = clk_two;
            CLK_SRC_TERM: sel = clock_term;
            default: sel = 1'b0;
        endcase
        cur_next.lvl = sel;
        cur_next.rise = sel & ~cur_reg.lvl;
        cur_next.fall = ~sel & cur_reg.lvl;
        // falling polarity picks the other edge and the low phase
        cur_next.io_edge = cfg[GC_POL_BIT] ? cur_next.fall
                                           : cur_next.rise;
        cur_next.io_act = cfg[GC_POL_BIT] ? ~sel : sel;
        cur_next.rst = reset_sum;
        cur_next.pst = preset_sum;
        cur_next.typ = type_term;
        if (!rst_n)
        begin
            cur_next = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        cur_reg <= cur_next;
    end

    assign rise = cur_reg.rise;
    assign fall = cur_reg.fall;
    assign io_edge = cur_reg.io_edge;
    assign io_level = cur_reg.io_act;
    assign g_reset = cur_reg.rst;
    assign g_preset = cur_reg.pst;
    assign g_type = cur_reg.typ;
endmodule

// ---- hdl/pin_cell.sv ----
// Purpose: one pin cell: output routing, polarity, three-state, input store
// Assumes: pin value already synchronised and filtered
// Notes: latch mode is transparent during the active clock phase
`timescale 1ns/1ps
module pin_cell
    import pld_pkg::*;
#(
    parameter int N_SRC = 20 // number of logic cells to choose from
)
(
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [pld_pkg::PC_CFG_W-1:0] cfg, // cell configuration
    input wire logic [N_SRC-1:0] src_q, // logic cell outputs
    input wire logic [N_SRC-1:0] src_oe, // logic cell enables
    input wire logic pin_val, // stable pin level
    input wire logic clk_edge, // active edge from global cell
    input wire logic clk_level, // active phase from global cell
    output logic pad_out, // pin output level
    output logic pad_oe, // pin output enable, high drives
    output logic to_array // value presented to the array
);
    typedef struct packed {
        logic out;
        logic oe;
        logic store;
        logic arr;
    } pc_state_s;

    pc_state_s cur_reg;
    pc_state_s cur_next;
    logic [SRC_W-1:0] src;
    logic store_v;

    // output routing and input capture
    always_comb
    begin
        cur_next = cur_reg;
        src = cfg[PC_SRC_LSB +: SRC_W];
        store_v = cur_reg.store;
        // any logic cell, out-of-range choice drives nothing
        if (int'(src) < N_SRC)
        begin
            cur_next.out = src_q[src] ^ cfg[PC_INV_BIT];
            cur_next.oe = src_oe[src];
        end
        else
        begin
            cur_next.out = 1'b0;
            cur_next.oe = 1'b0;
        end
        if (cfg[PC_LATCH_BIT] ? clk_level : clk_edge)
        begin
            store_v = pin_val;
        end
        cur_next.store = store_v;
        cur_next.arr = cfg[PC_BYP_BIT] ? pin_val : store_v;
        if (!rst_n)
        begin
            cur_next = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        cur_reg <= cur_next;
    end

    assign pad_out = cur_reg.out;
    assign pad_oe = cur_reg.oe;
    assign to_array = cur_reg.arr;
endmodule

// ---- hdl/pld_io_and_global_cells.sv ----
// Purpose: pin cells, two global cells, logic cell registers, config store
// Assumes: array sum terms arrive on ref_clk; pins are asynchronous
// Notes: configuration words reached by word index on a plain port
// Contract
// - pin output chosen from any logic cell
// - pin input stored by register or latch
// - three-state pin drive with output inversion
// - pin store clocked by its group's global cell
// - pin store can be bypassed to array
// - global clock from pin one, two, term
// - pin cell clock polarity set per group
// - each logic cell has own clock polarity
// - global reset and preset from sum terms
// - one fast term selects register type
// - two global cells, cells split in halves
// - secure bit blocks readback until full erase
// - user signature word stored at programming
// - signature stays readable while secured
// - type term switches load to toggle counting
// - global outputs reach every served logic cell
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pld_io_and_global_cells
    import pld_pkg::*;
#(
    parameter int NP = 20, // pin cells
    parameter int NL = 20 // logic cells
)
(
    input wire logic ref_clk, // system clock, 50 MHz
    input wire logic rst_n, // sync reset, active low
    input wire logic [pld_pkg::ADDR_W-1:0] reg_addr, // word index
    input wire logic [pld_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [pld_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
    input wire logic dedicated_clock_pin_one, // first clock pin
    input wire logic dedicated_clock_pin_two, // second clock pin
    input wire logic [NP-1:0] pin_in, // pin levels seen at the pads
    output logic [NP-1:0] pin_out, // pin drive levels
    output logic [NP-1:0] pin_oe, // pin enables, high drives
    input wire logic [NL-1:0] lcc_d_sum, // data sum per logic cell
    input wire logic [NL-1:0] lcc_oe_sum, // enable sum per logic cell
    input wire logic [pld_pkg::N_GRP-1:0] clock_term, // clock terms
    input wire logic [pld_pkg::N_GRP-1:0] reset_sum, // reset sums
    input wire logic [pld_pkg::N_GRP-1:0] preset_sum, // preset sums
    input wire logic [pld_pkg::N_GRP-1:0] type_term, // type terms
    output logic [NP-1:0] pin_to_array, // pin values into the array
    output logic [NL-1:0] lcc_q // logic cell register outputs
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] stable;
        logic [NUM_CFG-1:0][DATA_W-1:0] cfg;
        logic [DATA_W-1:0] sig;
        logic secure;
        logic [DATA_W-1:0] rdata;
        logic [NL-1:0] q;
    } top_state_s;

    top_state_s cur_reg;
    top_state_s cur_next;

    logic [N_GRP-1:0] g_rise;
    logic [N_GRP-1:0] g_fall;
    logic [N_GRP-1:0] g_io_edge;
    logic [N_GRP-1:0] g_io_level;
    logic [N_GRP-1:0] g_reset;
    logic [N_GRP-1:0] g_preset;
    logic [N_GRP-1:0] g_type;
    logic [NP-1:0] arr_bits;

    // ------------------------------------------------------------
    // global cells, one per group
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_GRP; g++)
        begin : gen_global
            // two independent cells, each with its own config word
            global_cell u_global (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .cfg(cur_reg.cfg[int'(IDX_GLOBAL_A) + g][GC_CFG_W-1:0]),
                .clk_one(cur_reg.stable[NP]),
                .clk_two(cur_reg.stable[NP+1]),
                .clock_term(clock_term[g]),
                .reset_sum(reset_sum[g]),
                .preset_sum(preset_sum[g]),
                .type_term(type_term[g]),
                .rise(g_rise[g]),
                .fall(g_fall[g]),
                .io_edge(g_io_edge[g]),
                .io_level(g_io_level[g]),
                .g_reset(g_reset[g]),
                .g_preset(g_preset[g]),
                .g_type(g_type[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // pin cells; first half on group A, second half on group B
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NP; p++)
        begin : gen_pin
            localparam int GP = (p < NP / 2) ? 0 : 1;
            pin_cell #(
                .N_SRC(NL)
            ) u_pin (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .cfg(cur_reg.cfg[int'(IDX_PIN_FIRST) + p][PC_CFG_W-1:0]),
                .src_q(cur_reg.q),
                .src_oe(lcc_oe_sum),
                .pin_val(cur_reg.stable[p]),
                .clk_edge(g_io_edge[GP]),
                .clk_level(g_io_level[GP]),
                .pad_out(pin_out[p]),
                .pad_oe(pin_oe[p]),
                .to_array(arr_bits[p])
            );
        end
    endgenerate

    assign pin_to_array = arr_bits;

    // ------------------------------------------------------------
    // next state: synchronisers, register port, logic cell registers
    // ------------------------------------------------------------
    always_comb
    begin
        logic [N_GRP-1:0] grp_edge;
        logic grp;
        logic pol;
        logic cell_edge;
        grp_edge = '0;
        grp = 1'b0;
        pol = 1'b0;
        cell_edge = 1'b0;
        cur_next = cur_reg;

        // three-stage sampling; a level counts once stages two and
        // three agree, so a single-cycle glitch never reaches a cell
        cur_next.s1 = {dedicated_clock_pin_two, dedicated_clock_pin_one,
                       pin_in};
        cur_next.s2 = cur_reg.s1;
        cur_next.s3 = cur_reg.s2;
        for (int b = 0; b < SYNC_W; b++)
        begin
            if (cur_reg.s2[b] == cur_reg.s3[b])
            begin
                cur_next.stable[b] = cur_reg.s3[b];
            end
        end

        // read data stands for exactly one cycle after the strobe
        cur_next.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr <= IDX_LCC_POL)
            begin
                // configuration hidden while secured
                if (!cur_reg.secure)
                begin
                    cur_next.rdata = cur_reg.cfg[reg_addr];
                end
            end
            else if (reg_addr == IDX_CTRL)
            begin
                cur_next.rdata[CTRL_SECURE_BIT] = cur_reg.secure;
            end
            else if (reg_addr == IDX_SIG)
            begin
                cur_next.rdata = cur_reg.sig;
            end
            else if (reg_addr == IDX_LCC_STAT)
            begin
                cur_next.rdata[NL-1:0] = cur_reg.q;
            end
            else if (reg_addr == IDX_ARR_STAT)
            begin
                cur_next.rdata[NP-1:0] = arr_bits;
            end
        end

        // writes; erase is always honoured, everything else only
        // while the part is not secured
        if (reg_wr)
        begin
            if (reg_addr == IDX_CTRL && reg_wdata[CTRL_ERASE_BIT])
            begin
                cur_next.cfg = '0;
                cur_next.sig = '0;
                cur_next.secure = 1'b0;
            end
            else if (reg_addr == IDX_CTRL)
            begin
                // the bit only sets; clearing needs a full erase
                if (reg_wdata[CTRL_SECURE_BIT])
                begin
                    cur_next.secure = 1'b1;
                end
            end
            else if (cur_reg.secure)
            begin
                cur_next.sig = cur_reg.sig;
            end
            else if (reg_addr <= IDX_LCC_POL)
            begin
                cur_next.cfg[reg_addr] = reg_wdata;
            end
            else if (reg_addr == IDX_SIG)
            begin
                cur_next.sig = reg_wdata;
            end
        end

        // logic cell registers; every cell sees its group's signals
        for (int j = 0; j < NL; j++)
        begin
            grp = (j < NL / 2) ? 1'b0 : 1'b1;
            pol = cur_reg.cfg[IDX_LCC_POL][j];
            grp_edge = pol ? g_fall : g_rise;
            cell_edge = grp_edge[grp];
            // reset beats preset; neither crosses into the other group
            if (g_reset[grp])
            begin
                cur_next.q[j] = 1'b0;
            end
            else if (g_preset[grp])
            begin
                cur_next.q[j] = 1'b1;
            end
            else if (cell_edge)
            begin
                // type term high: toggle to count, low: load data
                if (g_type[grp])
                begin
                    cur_next.q[j] = cur_reg.q[j] ^ lcc_d_sum[j];
                end
                else
                begin
                    cur_next.q[j] = lcc_d_sum[j];
                end
            end
        end

        if (!rst_n)
        begin
            cur_next = '0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        cur_reg <= cur_next;
    end

    assign reg_rdata = cur_reg.rdata;
    assign lcc_q = cur_reg.q;
endmodule

// ---- tb/pld_checker_asserts.sv ----
// Purpose: assertions on the register port and the group control terms
// Assumes: one clock domain, synchronous active-low reset
// Notes: a small shadow follows the secure bit and the signature word
`timescale 1ns/1ps
module pld_checker
    import pld_pkg::*;
#(
    parameter int NL = 20 // logic cells
)
(
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [pld_pkg::ADDR_W-1:0] reg_addr, // word index
    input wire logic [pld_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [pld_pkg::DATA_W-1:0] reg_rdata, // read data
    input wire logic [pld_pkg::N_GRP-1:0] reset_sum, // reset sums
    input wire logic [pld_pkg::N_GRP-1:0] preset_sum, // preset sums
    input wire logic [NL-1:0] lcc_q // logic cell outputs
);
    localparam int H = NL / 2;
    typedef struct packed {
        logic sec;
        logic [DATA_W-1:0] sig;
    } shadow_s;
    shadow_s shadow_reg;
    shadow_s shadow_next;
    logic ctl_wr;

    assign ctl_wr = reg_wr && reg_addr == IDX_CTRL;
    // shadow state; erase beats a set in the same write
    always_comb
    begin
        shadow_next = shadow_reg;
        if (reg_wr && reg_addr == IDX_SIG && !shadow_reg.sec)
            shadow_next.sig = reg_wdata;
        if (ctl_wr && reg_wdata[CTRL_SECURE_BIT])
            shadow_next.sec = 1'b1;
        if (ctl_wr && reg_wdata[CTRL_ERASE_BIT])
            shadow_next = '0;
    end
    always_ff @(posedge ref_clk)
        shadow_reg <= rst_n ? shadow_next : '0;

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence locked_rd;
        reg_rd && reg_addr <= IDX_LCC_POL && shadow_reg.sec;
    endsequence
    sequence erase_wr;
        ctl_wr && reg_wdata[CTRL_ERASE_BIT];
    endsequence
    // terms held two cycles so either pipeline depth has landed
    a_secure_block: assert property (
        locked_rd |=> reg_rdata == '0) else $error("config read leaked");
    a_ctrl_secure: assert property (
        reg_rd && reg_addr == IDX_CTRL |=>
        reg_rdata[0] == $past(shadow_reg.sec)) else $error("secure bit");
    a_sig_read: assert property (
        reg_rd && reg_addr == IDX_SIG |=>
        reg_rdata == $past(shadow_reg.sig)) else $error("signature read");
    a_erase_ctrl: assert property (
        erase_wr ##1 !ctl_wr ##1 (reg_rd && reg_addr == IDX_CTRL) |=>
        !reg_rdata[0]) else $error("erase kept secure");
    a_a_reset: assert property (
        reset_sum[0] [*2] |-> ##2 lcc_q[H-1:0] == '0)
        else $error("group a reset");
    a_a_preset: assert property (
        (preset_sum[0] && !reset_sum[0]) [*2] |-> ##2
        lcc_q[H-1:0] == {H{1'b1}}) else $error("group a preset");
    a_b_reset: assert property (
        reset_sum[1] [*2] |-> ##2 lcc_q[NL-1:H] == '0)
        else $error("group b reset");
    a_b_preset: assert property (
        (preset_sum[1] && !reset_sum[1]) [*2] |-> ##2
        lcc_q[NL-1:H] == {(NL-H){1'b1}}) else $error("group b preset");
endmodule

bind pld_io_and_global_cells pld_checker #(.NL(NL)) u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reset_sum(reset_sum),
    .preset_sum(preset_sum),
    .lcc_q(lcc_q)
);

// ---- tb/board_model.sv ----
// Purpose: board around the pads, driving pins the device leaves free
// Assumes: no pull resistors; board holds its own level on free pins
// Notes: a driven pad shows the device level, never the board's
`timescale 1ns/1ps
module board_model
    import pld_pkg::*;
(
    input wire logic [pld_pkg::N_PIN-1:0] pin_out, // device levels
    input wire logic [pld_pkg::N_PIN-1:0] pin_oe, // device enables
    input wire logic [pld_pkg::N_PIN-1:0] ext_val, // board levels
    output logic [pld_pkg::N_PIN-1:0] pin_in // level at each pad
);
    // wired pad level from both parties' drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for pin cells, global cells and config
// Assumes: 50 MHz ref_clk, reset held 16 cycles
// Notes: group clocks come from slow pulses on clock pins or terms
`timescale 1ns/1ps
module testbench;
    import pld_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic dedicated_clock_pin_one = 1'b0;
    logic dedicated_clock_pin_two = 1'b0;
    logic [N_PIN-1:0] pin_in, pin_out, pin_oe, pin_to_array;
    logic [N_PIN-1:0] ext_val = '0;
    logic [N_LCC-1:0] lcc_d_sum = '0;
    logic [N_LCC-1:0] lcc_oe_sum = '0;
    logic [N_LCC-1:0] lcc_q;
    logic [N_GRP-1:0] clock_term = '0;
    logic [N_GRP-1:0] reset_sum = '0;
    logic [N_GRP-1:0] preset_sum = '0;
    logic [N_GRP-1:0] type_term = '0;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #10 ref_clk = ~ref_clk;

    pld_io_and_global_cells dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .dedicated_clock_pin_one(dedicated_clock_pin_one),
        .dedicated_clock_pin_two(dedicated_clock_pin_two),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .lcc_d_sum(lcc_d_sum), .lcc_oe_sum(lcc_oe_sum),
        .clock_term(clock_term), .reset_sum(reset_sum),
        .preset_sum(preset_sum), .type_term(type_term),
        .pin_to_array(pin_to_array), .lcc_q(lcc_q)
    );
    board_model board (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .pin_in(pin_in)
    );

    // -------------------------------------
    // shared tasks
    // -------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // strobe is lowered then one edge passes, so calls never collide
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        hold(1);
        reg_wr <= 1'b0;
        hold(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        hold(1);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
        hold(1);
    endtask
    // slow pulse: the pin samplers need several cycles to settle
    task automatic pulse(input int s);
        case (s)
            0: dedicated_clock_pin_one <= 1'b1;
            1: dedicated_clock_pin_two <= 1'b1;
            default: clock_term[s-2] <= 1'b1;
        endcase
        hold(8);
        dedicated_clock_pin_one <= 1'b0;
        dedicated_clock_pin_two <= 1'b0;
        clock_term <= '0;
        hold(8);
    endtask
    task automatic gsr(input logic [1:0] rs, ps);
        reset_sum <= rs;
        preset_sum <= ps;
        hold(3);
        reset_sum <= '0;
        preset_sum <= '0;
        hold(3);
    endtask

    // -------------------------------------
    // scenarios
    // -------------------------------------
    task automatic t_regs();
        rd(IDX_CTRL, 32'h0);
        rd(5'h1C, 32'h0);
        wr(5'h02, 32'h8F);
        rd(5'h02, 32'h8F);
        wr(IDX_SIG, 32'hA5C3_0F96);
        rd(IDX_SIG, 32'hA5C3_0F96);
        wr(IDX_CTRL, 32'h1);
        rd(IDX_CTRL, 32'h1);
        rd(5'h02, 32'h0);
        wr(IDX_SIG, 32'h1234_5678);
        rd(IDX_SIG, 32'hA5C3_0F96);
        wr(IDX_CTRL, 32'h3);
        rd(IDX_CTRL, 32'h0);
        rd(IDX_SIG, 32'h0);
        rd(5'h02, 32'h0);
        wr(5'h02, 32'h41);
        rd(5'h02, 32'h41);
        wr(5'h02, 32'h0);
    endtask
    task automatic t_clk_sel();
        lcc_d_sum <= '1;
        wr(IDX_GLOBAL_A + 5'h01, 32'h1);
        pulse(0);
        chk("lcc_q", 32'(lcc_q), 32'h003FF);
        pulse(1);
        chk("lcc_q", 32'(lcc_q), 32'hFFFFF);
        lcc_d_sum <= '0;
        wr(IDX_GLOBAL_A, 32'h2);
        pulse(2);
        chk("lcc_q", 32'(lcc_q), 32'hFFC00);
        wr(IDX_GLOBAL_A + 5'h01, 32'h2);
        pulse(3);
        chk("lcc_q", 32'(lcc_q), 32'h0);
    endtask
    // group a counts while group b loads from the same sums
    task automatic t_type_gsr();
        wr(IDX_GLOBAL_A, 32'h0);
        wr(IDX_GLOBAL_A + 5'h01, 32'h0);
        gsr(2'b00, 2'b11);
        type_term <= 2'b01;
        lcc_d_sum <= 20'h00405;
        pulse(0);
        chk("lcc_q", 32'(lcc_q), 32'h007FA);
        type_term <= 2'b00;
        gsr(2'b00, 2'b01);
        chk("lcc_q", 32'(lcc_q), 32'h007FF);
        gsr(2'b10, 2'b00);
        chk("lcc_q", 32'(lcc_q), 32'h003FF);
        gsr(2'b01, 2'b01);
        chk("lcc_q", 32'(lcc_q), 32'h0);
    endtask
    task automatic t_pin_out();
        gsr(2'b00, 2'b10);
        lcc_oe_sum <= 20'h08000;
        wr(5'h03, 32'h0F);
        hold(4);
        chk("pin_out", 32'(pin_out[3]), 32'h1);
        chk("pin_oe", 32'(pin_oe[3]), 32'h1);
        wr(5'h03, 32'h2F);
        wr(5'h0C, 32'h22);
        hold(4);
        chk("pin_out", 32'(pin_out[3]), 32'h0);
        chk("pin_out", 32'(pin_out[12]), 32'h1);
        chk("pin_oe", 32'(pin_oe[12]), 32'h0);
        lcc_oe_sum <= '1;
        wr(5'h03, 32'h14);
        hold(4);
        chk("pin_oe", 32'(pin_oe[3]), 32'h0);
        lcc_oe_sum <= '0;
        wr(5'h03, 32'h0);
        wr(5'h0C, 32'h0);
    endtask
    task automatic t_pin_in();
        ext_val[5] <= 1'b1;
        hold(10);
        chk("to_array", 32'(pin_to_array[5]), 32'h0);
        pulse(0);
        chk("to_array", 32'(pin_to_array[5]), 32'h1);
        wr(5'h05, 32'h80);
        ext_val[5] <= 1'b0;
        hold(10);
        chk("to_array", 32'(pin_to_array[5]), 32'h0);
        wr(5'h05, 32'h0);
        wr(IDX_GLOBAL_A, 32'h4);
        dedicated_clock_pin_one <= 1'b1;
        hold(8);
        chk("to_array", 32'(pin_to_array[5]), 32'h1);
        dedicated_clock_pin_one <= 1'b0;
        hold(8);
        chk("to_array", 32'(pin_to_array[5]), 32'h0);
        wr(5'h05, 32'h40);
        ext_val[5] <= 1'b1;
        hold(8);
        chk("to_array", 32'(pin_to_array[5]), 32'h1);
        dedicated_clock_pin_one <= 1'b1;
        hold(8);
        ext_val[5] <= 1'b0;
        hold(8);
        chk("to_array", 32'(pin_to_array[5]), 32'h1);
        dedicated_clock_pin_one <= 1'b0;
        wr(IDX_GLOBAL_A, 32'h0);
    endtask
    // cell 0 on the falling edge, its group still rising for pins
    task automatic t_lcc_pol();
        gsr(2'b11, 2'b00);
        lcc_d_sum <= '1;
        wr(IDX_LCC_POL, 32'h1);
        dedicated_clock_pin_one <= 1'b1;
        hold(8);
        chk("lcc_q", 32'(lcc_q), 32'hFFFFE);
        dedicated_clock_pin_one <= 1'b0;
        hold(8);
        chk("lcc_q", 32'(lcc_q), 32'hFFFFF);
        rd(IDX_LCC_STAT, 32'hFFFFF);
    endtask

    // hang guard, several times the expected run length
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            end_sim();
        end
    end

    initial
    begin
        hold(16);
        rst_n <= 1'b1;
        hold(2);
        t_regs();
        t_clk_sel();
        t_type_gsr();
        t_pin_out();
        t_pin_in();
        t_lcc_pol();
        end_sim();
    end
endmodule
